// ---- hw/sfp_defines.svh ----
// Timing counts and command codes for the flash power, pause and reset block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------------------
`define SFP_OP_LOWEST_POWER 8'h79
`define SFP_OP_SOFT_RESET   8'hf0
`define SFP_OP_CONFIRM      8'hd0
`define SFP_OP_WR_STATUS2   8'h31

// ----------------------------------------------------------------------------
// Timing, in ns, and derived cycle counts at 10 ns per cycle
// ----------------------------------------------------------------------------
`define SFP_CLK_PERIOD_NS     10
`define SFP_ENTRY_TIME_NS     3000
`define SFP_WAKE_LOW_MIN_NS   20
`define SFP_EXIT_TIME_NS      70000
`define SFP_RESET_TIME_NS     60000
`define SFP_ENTRY_CYC   ((`SFP_ENTRY_TIME_NS) / (`SFP_CLK_PERIOD_NS))
`define SFP_WAKE_LOW_CYC \
  ((`SFP_WAKE_LOW_MIN_NS + `SFP_CLK_PERIOD_NS - 1) / (`SFP_CLK_PERIOD_NS))
`define SFP_EXIT_CYC    ((`SFP_EXIT_TIME_NS) / (`SFP_CLK_PERIOD_NS))
`define SFP_RESET_CYC   ((`SFP_RESET_TIME_NS) / (`SFP_CLK_PERIOD_NS))

`endif

// ---- hw/sfp_pkg.sv ----
// Types for the flash power, pause and reset block.
// Assumes nothing beyond the defines header.
package sfp_pkg;

  // --------------------------------------------------------------------------
  // Power state, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SFP_STANDBY  = 4'h1,
    SFP_ENTERING = 4'h2,
    SFP_LOWEST   = 4'h4,
    SFP_EXITING  = 4'h8
  } sfp_pwr_t;

endpackage

// ---- hw/sfp_core.sv ----
// Lowest-power mode, hold pause and soft reset control of a serial flash.
// Assumes serial pins arrive asynchronous to clk_i; array engine is outside.
`include "sfp_defines.svh"

module sfp_core
  import sfp_pkg::*;
#(
  parameter int unsigned ENTRY_CYC = `SFP_ENTRY_CYC,
  parameter int unsigned EXIT_CYC  = `SFP_EXIT_CYC,
  parameter int unsigned RESET_CYC = `SFP_RESET_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic en_i,
  // Serial pins
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  input  wire logic wp_n_i,
  // Array engine
  input  wire logic busy_i,
  input  wire logic wel_set_i,
  output logic      cmd_ok_o,
  output logic      abort_o,
  output logic      paused_o,
  output logic      so_oe_allow_o,
  output logic      wp_active_o,
  // Status
  output logic      write_enable_latch_o,
  output logic      soft_reset_enable_bit_o,
  output logic      lowest_power_o,
  output logic      standby_o
);

  localparam int unsigned CW = 17;

  // --------------------------------------------------------------------------
  // Pin synchronisers: change counts when stages two and three agree
  // --------------------------------------------------------------------------
  logic [4:0] s1_reg, s2_reg, s3_reg, pin_reg;
  logic [4:0] s1_next, s2_next, s3_next, pin_next;
  logic       cs_n, sck, si, hold_n;
  logic       sck_prev_reg, sck_prev_next;

  always_comb begin
    s1_next  = {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    pin_next = pin_reg;
    for (int i = 0; i < 5; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        pin_next[i] = s3_reg[i];
      end
    end
    sck_prev_next = pin_reg[1];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg       <= 5'h1d;
      s2_reg       <= 5'h1d;
      s3_reg       <= 5'h1d;
      pin_reg      <= 5'h1d;
      sck_prev_reg <= 1'b0;
    end else if (en_i) begin
      s1_reg       <= s1_next;
      s2_reg       <= s2_next;
      s3_reg       <= s3_next;
      pin_reg      <= pin_next;
      sck_prev_reg <= sck_prev_next;
    end
  end

  assign cs_n   = pin_reg[0];
  assign sck    = pin_reg[1];
  assign si     = pin_reg[2];
  assign hold_n = pin_reg[3];

  // --------------------------------------------------------------------------
  // Hold pause, follows hold only while clock low; deselect clears it at any clock level
  // --------------------------------------------------------------------------
  logic pause_reg, pause_next;
  logic cs_n_prev_reg, cs_n_prev_next;
  logic cs_rise, cs_fall, sck_rise;

  assign cs_rise  = cs_n && !cs_n_prev_reg;
  assign cs_fall  = !cs_n && cs_n_prev_reg;
  assign sck_rise = sck && !sck_prev_reg && !pause_reg;

  always_comb begin
    pause_next     = pause_reg;
    cs_n_prev_next = cs_n;
    if (cs_n) begin
      pause_next = 1'b0;
    end else if (!sck) begin
      pause_next = !hold_n;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pause_reg     <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end else if (en_i) begin
      pause_reg     <= pause_next;
      cs_n_prev_reg <= cs_n_prev_next;
    end
  end

  // --------------------------------------------------------------------------
  // Byte shifter and command decode
  // --------------------------------------------------------------------------
  logic [7:0] sh_reg, sh_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] nbytes_reg, nbytes_next;
  logic [7:0] op_reg, op_next;
  logic       conf_reg, conf_next;
  logic       drop_reg, drop_next;
  logic       any_bit_reg, any_bit_next;
  logic [7:0] sh_full;

  assign sh_full = {sh_reg[6:0], si};

  // --------------------------------------------------------------------------
  // Power state, timers and status bits
  // --------------------------------------------------------------------------
  sfp_pwr_t     pwr_reg, pwr_next;
  logic [CW-1:0] tmr_reg, tmr_next;
  logic [CW-1:0] rst_tmr_reg, rst_tmr_next;
  logic          wel_reg, wel_next;
  logic          soft_reset_enable_bit_reg, soft_reset_enable_bit_next;
  logic          abort_reg, abort_next;
  logic          asleep;

  assign asleep = (pwr_reg == SFP_LOWEST) || (pwr_reg == SFP_ENTERING);

  // Drop decision valid already in the select cycle
  logic          drop_now;

  assign drop_now = cs_fall ? (asleep || (pwr_reg == SFP_EXITING)) : drop_reg;

  always_comb begin
    sh_next      = sh_reg;
    bit_next     = bit_reg;
    nbytes_next  = nbytes_reg;
    op_next      = op_reg;
    conf_next    = conf_reg;
    drop_next    = drop_reg;
    any_bit_next = any_bit_reg;
    pwr_next     = pwr_reg;
    tmr_next     = tmr_reg;
    rst_tmr_next = rst_tmr_reg;
    wel_next     = wel_reg;
    soft_reset_enable_bit_next    = soft_reset_enable_bit_reg;
    abort_next   = 1'b0;

    if (cs_fall) begin
      bit_next     = 3'h0;
      nbytes_next  = 2'h0;
      op_next      = 8'h00;
      conf_next    = 1'b0;
      any_bit_next = 1'b0;
      drop_next    = asleep || (pwr_reg == SFP_EXITING);
    end

    if (!cs_n && sck_rise) begin
      sh_next      = sh_full;
      bit_next     = bit_reg + 3'h1;
      any_bit_next = 1'b1;
      if (bit_reg == 3'h7) begin
        if (nbytes_reg != 2'h3) begin
          nbytes_next = nbytes_reg + 2'h1;
        end
        if (nbytes_reg == 2'h0) begin
          op_next = sh_full;
        end
        if (nbytes_reg == 2'h1 && op_reg == `SFP_OP_SOFT_RESET) begin
          conf_next = (sh_full == `SFP_OP_CONFIRM);
        end
        if (nbytes_reg == 2'h1 && op_reg == `SFP_OP_WR_STATUS2 && !drop_reg) begin
          soft_reset_enable_bit_next = sh_full[4];
        end
      end
      if (pwr_reg == SFP_LOWEST && !any_bit_reg) begin
        pwr_next = SFP_EXITING;
        tmr_next = CW'(EXIT_CYC);
      end
    end

    if (wel_set_i && !drop_reg) begin
      wel_next = 1'b1;
    end

    if (cs_rise) begin
      if (pause_reg) begin
        abort_next = 1'b1;
        wel_next   = 1'b0;
      end else if (!drop_reg && bit_reg == 3'h0) begin
        if (op_reg == `SFP_OP_LOWEST_POWER && nbytes_reg != 2'h0 && !busy_i) begin
          pwr_next = SFP_ENTERING;
          tmr_next = CW'(ENTRY_CYC);
        end
        if (op_reg == `SFP_OP_SOFT_RESET && conf_reg && nbytes_reg >= 2'h2 && soft_reset_enable_bit_reg) begin
          rst_tmr_next = CW'(RESET_CYC);
        end
      end
      if (pwr_reg == SFP_LOWEST) begin
        pwr_next = SFP_EXITING;
        tmr_next = CW'(EXIT_CYC);
      end
    end

    if (rst_tmr_reg != '0) begin
      rst_tmr_next = rst_tmr_reg - CW'(1);
      if (rst_tmr_reg == CW'(1)) begin
        abort_next = 1'b1;
        wel_next   = 1'b0;
      end
    end

    case (pwr_reg)
      SFP_STANDBY: begin
      end
      SFP_ENTERING: begin
        if (tmr_reg > CW'(1)) begin
          tmr_next = tmr_reg - CW'(1);
        end else begin
          pwr_next = SFP_LOWEST;
        end
      end
      SFP_LOWEST: begin
      end
      SFP_EXITING: begin
        if (pwr_next == SFP_EXITING && tmr_reg > CW'(1)) begin
          tmr_next = tmr_reg - CW'(1);
        end else if (pwr_next == SFP_EXITING) begin
          pwr_next = SFP_STANDBY;
        end
      end
      default: begin
        pwr_next = SFP_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh_reg      <= 8'h00;
      bit_reg     <= 3'h0;
      nbytes_reg  <= 2'h0;
      op_reg      <= 8'h00;
      conf_reg    <= 1'b0;
      drop_reg    <= 1'b0;
      any_bit_reg <= 1'b0;
      pwr_reg     <= SFP_STANDBY;
      tmr_reg     <= '0;
      rst_tmr_reg <= '0;
      wel_reg     <= 1'b0;
      soft_reset_enable_bit_reg    <= 1'b0;
      abort_reg   <= 1'b0;
    end else if (en_i) begin
      sh_reg      <= sh_next;
      bit_reg     <= bit_next;
      nbytes_reg  <= nbytes_next;
      op_reg      <= op_next;
      conf_reg    <= conf_next;
      drop_reg    <= drop_next;
      any_bit_reg <= any_bit_next;
      pwr_reg     <= pwr_next;
      tmr_reg     <= tmr_next;
      rst_tmr_reg <= rst_tmr_next;
      wel_reg     <= wel_next;
      soft_reset_enable_bit_reg    <= soft_reset_enable_bit_next;
      abort_reg   <= abort_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign cmd_ok_o                = !cs_n && !drop_now && !pause_reg;
  assign abort_o                 = abort_reg;
  assign paused_o                = pause_reg;
  assign so_oe_allow_o           = !cs_n && !pause_reg && !drop_now;
  assign wp_active_o             = !pin_reg[4];
  assign write_enable_latch_o    = wel_reg;
  assign soft_reset_enable_bit_o = soft_reset_enable_bit_reg;
  assign lowest_power_o          = (pwr_reg == SFP_LOWEST);
  assign standby_o               = (pwr_reg == SFP_STANDBY);

endmodule // sfp_core

// ---- dv/sfp_core_asserts.sv ----
// Port checks for the power, pause and reset block.
// Assumes one clock, clk_i, and reset nrst_i active low.
module sfp_core_asserts (
  // Clock and pins
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wp_n_i,
  // Outputs
  input wire logic cmd_ok_o,
  input wire logic abort_o,
  input wire logic paused_o,
  input wire logic so_oe_allow_o,
  input wire logic wp_active_o,
  input wire logic write_enable_latch_o,
  input wire logic soft_reset_enable_bit_o,
  input wire logic lowest_power_o,
  input wire logic standby_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  reset_standby_a: assert property ($rose(nrst_i) |-> standby_o && !lowest_power_o)
    else $error("no standby after reset");
  entry_path_a: assert property ($rose(lowest_power_o) |-> !$past(standby_o))
    else $error("lowest power entered from standby");
  asleep_mute_a: assert property (lowest_power_o |-> !cmd_ok_o)
    else $error("command allowed while asleep");
  mode_excl_a: assert property (!(lowest_power_o && standby_o))
    else $error("standby and lowest power together");
  pause_float_a: assert property (paused_o |-> !so_oe_allow_o && !cmd_ok_o)
    else $error("output or command live while paused");
  abort_pulse_a: assert property (abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  abort_keep_a: assert property (abort_o |-> $stable(soft_reset_enable_bit_o))
    else $error("abort changed reset enable");
  abort_wel_a: assert property (abort_o |-> ##[0:2] !write_enable_latch_o)
    else $error("write latch kept after abort");
  wp_follow_a: assert property ($fell(wp_n_i) |-> ##[1:8] wp_active_o)
    else $error("protect not honoured");
  cover property ($rose(lowest_power_o));
  cover property (abort_o);
  cover property ($rose(paused_o));
endmodule // sfp_core_asserts

bind sfp_core sfp_core_asserts sfp_core_asserts_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .wp_n_i(wp_n_i), .cmd_ok_o(cmd_ok_o),
  .abort_o(abort_o), .paused_o(paused_o), .so_oe_allow_o(so_oe_allow_o),
  .wp_active_o(wp_active_o), .write_enable_latch_o(write_enable_latch_o),
  .soft_reset_enable_bit_o(soft_reset_enable_bit_o),
  .lowest_power_o(lowest_power_o), .standby_o(standby_o));

// ---- dv/sfp_host.sv ----
// Serial host model driving select, clock, data and hold.
// Assumes the bench calls its tasks; pins change at falling clk.
module sfp_host (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // ----
  // Tasks
  // ----
  task automatic tick(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic sel;
    tick(1);
    cs_n_o = 1'b0;
    tick(6);
  endtask
  // Mode 0, msb first, six clk per phase
  task automatic bits(logic [7:0] b, int n);
    for (int i = 7; i > 7 - n; i--) begin
      si_o = b[i];
      tick(6);
      sck_o = 1'b1;
      tick(6);
      sck_o = 1'b0;
    end
  endtask
  // Released data line shows the inverse
  task automatic desel;
    tick(6);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    tick(12);
  endtask
  task automatic hold(logic v);
    hold_n_o = v;
  endtask
endmodule // sfp_host

// ---- dv/sfp_core_test.sv ----
// Self-checking bench for the power, pause and reset block.
// Assumes the host model and checker files are compiled first.
module sfp_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, busy = 0, wel_set = 0, wp_n = 1, ce = 1;
  logic cs_n, sck, si, hold_n, ok, ab, pa, so, wpa, write_enable_latch, en, lp, sb;
  int   n_errors = 0, checks_done = 0, n_abort = 0, cyc = 0, seed = 38584;
  int   m_lp = 0, m_en = 0, m_wel = 0, m_ab = 0;
  logic [31:0] r;
  always #5 clk = ~clk;
  sfp_host sfp_host_inst (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n));
  sfp_core #(.ENTRY_CYC(8), .EXIT_CYC(20), .RESET_CYC(10)) sfp_core_inst (
    .clk_i(clk), .nrst_i(nrst), .en_i(ce), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n), .busy_i(busy), .wel_set_i(wel_set),
    .cmd_ok_o(ok), .abort_o(ab), .paused_o(pa), .so_oe_allow_o(so), .wp_active_o(wpa),
    .write_enable_latch_o(write_enable_latch), .soft_reset_enable_bit_o(en),
    .lowest_power_o(lp), .standby_o(sb));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ab === 1'b1)
      n_abort <= n_abort + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  // ----
  // Tasks
  // ----
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] got, int exp);
    checks_done++;
    if (got !== exp[7:0]) begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic compare;
    chk("lowest_power_o", {7'h00, lp}, m_lp);
    chk("standby_o", {7'h00, sb}, 1 - m_lp);
    chk("soft_reset_enable_bit_o", {7'h00, en}, m_en);
    chk("write_enable_latch_o", {7'h00, write_enable_latch}, m_wel);
    chk("abort count", n_abort[7:0], m_ab);
  endtask
  // Any selection while asleep only wakes
  task automatic model(logic [15:0] d, int n);
    if (m_lp != 0)
      m_lp = 0;
    else if (n == 8 && d[15:8] == 8'h79 && busy === 1'b0)
      m_lp = 1;
    else if (n == 16 && d[15:8] == 8'h31)
      m_en = d[4];
    else if (n == 16 && d == 16'hf0d0 && m_en != 0) begin
      m_ab++;
      m_wel = 0;
    end
  endtask
  task automatic xfer(logic [15:0] d, int n);
    sfp_host_inst.sel();
    sfp_host_inst.bits(d[15:8], n > 8 ? 8 : n);
    if (n > 8)
      sfp_host_inst.bits(d[7:0], n - 8);
    sfp_host_inst.desel();
    model(d, n);
    tick(60);
    compare();
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    tick(3);
    nrst = 1;
    tick(6);
    compare();
    xfer(16'h7900, 7);
    busy = 1;
    xfer(16'h7900, 8);
    busy = 0;
    xfer(16'h7900, 8);
    xfer(16'h3110, 16);
    xfer(16'hf0d0, 16);
    xfer(16'h3110, 16);
    // Clock enable low: a full 31h 00h write must be lost
    ce = 0;
    sfp_host_inst.sel();
    sfp_host_inst.bits(8'h31, 8);
    sfp_host_inst.bits(8'h00, 8);
    sfp_host_inst.desel();
    ce = 1;
    tick(20);
    compare();
    wel_set = 1;
    tick(1);
    wel_set = 0;
    m_wel = 1;
    r = $random(seed);
    if (r[7:0] == 8'hd0)
      r[0] = 1'b1;
    xfer({8'hf0, r[7:0]}, 16);
    xfer(16'hf0d0, 15);
    busy = 1;
    xfer(16'hf0d0, 16);
    wel_set = 1;
    tick(1);
    wel_set = 0;
    sfp_host_inst.sel();
    sfp_host_inst.bits(8'h05, 4);
    chk("cmd_ok_o", {7'h00, ok}, 1);
    sfp_host_inst.hold(1'b0);
    tick(12);
    chk("paused_o", {7'h00, pa}, 1);
    chk("so_oe_allow_o", {7'h00, so}, 0);
    wp_n = 0;
    tick(12);
    chk("wp_active_o", {7'h00, wpa}, 1);
    wp_n = 1;
    sfp_host_inst.desel();
    sfp_host_inst.hold(1'b1);
    busy = 0;
    m_ab++;
    tick(40);
    compare();
    xfer(16'h7900, 8);
    xfer(16'h3100, 16);
    xfer(16'h7900, 8);
    // Wake pulse, then a reselect inside the exit time
    sfp_host_inst.sel();
    sfp_host_inst.desel();
    sfp_host_inst.sel();
    chk("cmd_ok_o", {7'h00, ok}, 0);
    sfp_host_inst.bits(8'h31, 8);
    sfp_host_inst.bits(8'h00, 8);
    sfp_host_inst.desel();
    m_lp = 0;
    tick(60);
    compare();
    xfer(16'h7900, 8);
    nrst = 0;
    tick(2);
    nrst = 1;
    m_lp = 0;
    m_en = 0;
    tick(8);
    compare();
    stop_test();
  end
endmodule // sfp_core_test
